// >>> dv/ipg_phy_model.sv
// Behavioural PHY and shared medium: raises and drops carrier on command.
// Assumes the bench calls sense() from its own process on a clock edge; the task's delay moves carrier off it.
`timescale 1ns/10ps

module ipg_phy_model (
    // Medium side.
    output logic carrier_sense
);

    // Carrier starts idle; the medium is quiet until a station transmits.
    initial begin
        carrier_sense = 1'b0;
    end

    // The delay puts carrier off the clock grid, as a real asynchronous PHY would.
    task automatic sense(input logic on);
        #13;
        carrier_sense = on;
    endtask : sense

endmodule : ipg_phy_model

// >>> dv/tb_top.sv
// Self-checking bench for the gap and deference block: registers and gap timing.
// Assumes the design files are compiled first and the PHY model beside this file.
`timescale 1ns/10ps
`include "ipg_cfg.svh"

module tb_top;

    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic tx_tick = 1'b0, tx_request = 1'b0, tx_active = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic tx_go, deferring, carrier_sense;
    int failures = 0;
    int checks = 0;
    // Bits of read data that rd compares; a scenario narrows it to judge one field.
    logic [31:0] rd_mask = 32'hFFFF_FFFF;

    ////////////////////////////////////////////////////////////////////////////
    // Clock, design and medium.
    always #25 ref_clk = ~ref_clk;

    ipg_deference uut (
        .ref_clk(ref_clk), .reset_n(reset_n),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .tx_tick(tx_tick), .tx_request(tx_request), .tx_active(tx_active),
        .tx_go(tx_go), .deferring(deferring), .carrier_sense(carrier_sense)
    );

    ipg_phy_model phy (
        .carrier_sense(carrier_sense)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Comparison and bus tasks.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Address and data are offered together and each is released when taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge ref_clk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bready <= 1'b0;
                chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
                done = 1'b1;
            end
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge ref_clk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rready <= 1'b0;
                chk("rdata", ed, s_axi_rdata & rd_mask);
                chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
                done = 1'b1;
            end
        end
    endtask : rd

    ////////////////////////////////////////////////////////////////////////////
    // Register scenario: reset value, widths, aliases, reserved bits, bad address.
    task automatic reg_test();
        rd(`IPG_OFS_STAT, 32'h0000_0001, `IPG_RESP_OKAY);
        rd(`IPG_OFS_CFG, 32'h0000_0C12, `IPG_RESP_OKAY);
        rd(`IPG_OFS_SET, 32'h0000_0C12, `IPG_RESP_OKAY);
        wr(`IPG_OFS_CFG, 32'hFFFF_FFFF, `IPG_STRB_WORD, `IPG_RESP_OKAY);
        rd(`IPG_OFS_CFG, 32'h0000_7F7F, `IPG_RESP_OKAY);
        wr(`IPG_OFS_CFG, 32'h0000_0000, 4'h1, `IPG_RESP_OKAY);
        wr(`IPG_OFS_CFG, 32'h0000_0000, 4'h2, `IPG_RESP_OKAY);
        rd(`IPG_OFS_CFG, 32'h0000_7F7F, `IPG_RESP_OKAY);
        wr(`IPG_OFS_CFG, 32'h0000_0000, `IPG_STRB_LO, `IPG_RESP_OKAY);
        rd(`IPG_OFS_CFG, 32'h0000_0000, `IPG_RESP_OKAY);
        wr(`IPG_OFS_SET, 32'h0000_0A05, `IPG_STRB_LO, `IPG_RESP_OKAY);
        rd(`IPG_OFS_CFG, 32'h0000_0A05, `IPG_RESP_OKAY);
        wr(`IPG_OFS_CLR, 32'h0000_0201, `IPG_STRB_WORD, `IPG_RESP_OKAY);
        rd(`IPG_OFS_CFG, 32'h0000_0804, `IPG_RESP_OKAY);
        wr(`IPG_OFS_INV, 32'hFFFF_FFFF, `IPG_STRB_WORD, `IPG_RESP_OKAY);
        rd(`IPG_OFS_CFG, 32'h0000_777B, `IPG_RESP_OKAY);
        // Byte writes through the aliases and any write to status change nothing.
        wr(`IPG_OFS_CLR, 32'hFFFF_FFFF, 4'h1, `IPG_RESP_OKAY);
        wr(`IPG_OFS_INV, 32'hFFFF_FFFF, 4'h4, `IPG_RESP_OKAY);
        wr(`IPG_OFS_STAT, 32'hFFFF_FFFF, `IPG_STRB_WORD, `IPG_RESP_OKAY);
        wr(`IPG_OFS_CFG, 32'hFFFF_0000, `IPG_STRB_HI, `IPG_RESP_OKAY);
        rd(`IPG_OFS_CFG, 32'h0000_777B, `IPG_RESP_OKAY);
        wr(8'h20, 32'h0000_0001, `IPG_STRB_WORD, `IPG_RESP_SLVERR);
        rd(8'h20, 32'h0000_0000, `IPG_RESP_SLVERR);
    endtask : reg_test

    ////////////////////////////////////////////////////////////////////////////
    // Gap scenario: a tick every six cycles, optional carrier after car_at ticks.
    // A carrier in the window restarts the count, so ticks are counted from its end.
    task automatic gap_run(input logic [6:0] p1, input logic [6:0] p2, input int car_at,
                           input bit late);
        int n;
        int k;
        bit went;
        bit car_done;
        n = 0;
        k = 0;
        went = 1'b0;
        car_done = 1'b0;
        wr(`IPG_OFS_CFG, {16'h0000, 1'b0, p1, 1'b0, p2}, `IPG_STRB_WORD, `IPG_RESP_OKAY);
        @(posedge ref_clk);
        tx_active <= 1'b1;
        repeat (3) @(posedge ref_clk);
        tx_active <= 1'b0;
        while (!went && k < 600) begin
            k++;
            @(posedge ref_clk);
            tx_tick <= (k % 6 == 0);
            if (k % 6 == 0) n++;
            if (k % 6 == 3 && n == car_at && !car_done) begin
                car_done = 1'b1;
                phy.sense(1'b1);
                // Carrier is synchronised by now: a window carrier defers, a late one not.
                repeat (8) @(posedge ref_clk);
                chk("deferring", {31'h0, !late}, {31'h0, deferring});
                if (!late) begin
                    phy.sense(1'b0);
                    repeat (8) @(posedge ref_clk);
                    n = 0;
                end
            end
            #1 went = (tx_go === 1'b1);
        end
        chk("tx_go", 32'h1, {31'h0, went});
        chk("ticks", {25'h0, p2}, n[31:0]);
        // The only late carrier of the run must show in the late-event count.
        if (late) begin
            rd_mask = 32'h00FF_0000;
            rd(`IPG_OFS_STAT, 32'h0001_0000, `IPG_RESP_OKAY);
            rd_mask = 32'hFFFF_FFFF;
        end
        @(posedge ref_clk);
        tx_tick <= 1'b0;
        phy.sense(1'b0);
    endtask : gap_run

    ////////////////////////////////////////////////////////////////////////////
    // Verdict, main sequence and watchdog.
    task automatic summarize();
        if (failures == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        tx_request <= 1'b1;
        reg_test();
        gap_run(7'd6, 7'd10, -1, 1'b0);
        gap_run(7'd0, 7'd4, -1, 1'b0);
        gap_run(7'd12, 7'd18, -1, 1'b0);
        gap_run(7'd6, 7'd10, 2, 1'b0);
        gap_run(7'd6, 7'd10, 7, 1'b1);
        summarize();
    end

    // The whole run needs about 500 cycles; sixty times that means a hang.
    initial begin
        repeat (30000) @(posedge ref_clk);
        failures++;
        summarize();
    end

endmodule : tb_top

// >>> verilog/ipg_cfg.svh
// Constants of the inter-packet gap and deference block: offsets, fields,
// reset values and counter limits.
// Assumes inclusion by bare name from the design files that need it.
`ifndef IPG_CFG_SVH
`define IPG_CFG_SVH

// Register byte offsets on the AXI4-Lite slave.
`define IPG_ADDR_W 8
`define IPG_OFS_CFG 8'h00
`define IPG_OFS_SET 8'h04
`define IPG_OFS_CLR 8'h08
`define IPG_OFS_INV 8'h0C
`define IPG_OFS_STAT 8'h10

// Gap configuration: reset value, implemented bits and field positions.
`define IPG_CFG_RESET 32'h0000_0C12
`define IPG_IMPL_MASK 32'h0000_7F7F
`define IPG_P1_MSB 14
`define IPG_P1_LSB 8
`define IPG_P2_MSB 6
`define IPG_P2_LSB 0

// Status register field positions.
`define IPG_ST_PHASE_LSB 0
`define IPG_ST_CARRIER 4
`define IPG_ST_DEFER_LSB 8
`define IPG_ST_LATE_LSB 16

// Accepted write strobe patterns: one word or one half-word.
`define IPG_STRB_WORD 4'hF
`define IPG_STRB_LO 4'h3
`define IPG_STRB_HI 4'hC

// Bus responses and counter limit.
`define IPG_RESP_OKAY 2'b00
`define IPG_RESP_SLVERR 2'b10
`define IPG_CNT_MAX 7'h7F

`endif

// >>> verilog/ipg_deference.sv
// Non-back-to-back inter-packet gap and deference for a MAC transmitter,
// with its configuration and status registers on an AXI4-Lite slave.
// Assumes a 20 MHz ref_clk, a time-unit tick from the MAC on that clock,
// and an asynchronous carrier sense from the PHY.
//
// What this block does
// (R1) Carrier seen during the first gap part makes the MAC defer.
// (R2) Carrier first seen after part one is ignored; gap completes, then transmit.
// (R3) Software keeps the first part between zero and the second; twelve advised.
// (R4) The 7-bit second part at bits 6-0 sets the gap length.
// (R5) Half-word and word writes act, byte writes are ignored, on all aliases.
// (R6) Bits 31-15 and bit 7 read zero and ignore writes.
// (R7) Gap timing starts when transmit or carrier ends, part one first.
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "ipg_cfg.svh"

module ipg_deference (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset_n,
    // AXI4-Lite write address and data.
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response.
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read.
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // MAC transmit side.
    input wire logic tx_tick,
    input wire logic tx_request,
    input wire logic tx_active,
    output logic tx_go,
    output logic deferring,
    // PHY side.
    input wire logic carrier_sense
);
    import ipg_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Reset release and carrier synchroniser.

    logic rst_meta_q;
    logic rst_n;
    logic crs_1_q;
    logic crs_2_q;
    logic crs_3_q;
    logic carrier_q;

    // Reset asserts at once but releases through two flops.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // Carrier only counts once the second and third stages agree, which
    // also filters single-cycle glitches on the pin.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            crs_1_q <= 1'b0;
            crs_2_q <= 1'b0;
            crs_3_q <= 1'b0;
            carrier_q <= 1'b0;
        end else begin
            crs_1_q <= carrier_sense;
            crs_2_q <= crs_1_q;
            crs_3_q <= crs_2_q;
            if (crs_2_q == crs_3_q) begin
                carrier_q <= crs_3_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave.

    logic [31:0] cfg_q;
    logic [7:0] defer_cnt_q;
    logic [7:0] late_cnt_q;
    logic [7:0] aw_addr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_hold_q;
    logic w_hold_q;
    ipg_phase_type state_q;
    ipg_phase_type state_d;

    // Handshake decode.
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire w_do = aw_hold_q & w_hold_q & ~s_axi_bvalid;

    // Write decode; byte-lane patterns other than a half or a word drop.
    wire strb_ok = (wstrb_q == `IPG_STRB_WORD) || (wstrb_q == `IPG_STRB_LO) ||
                   (wstrb_q == `IPG_STRB_HI); // see (R5)
    wire [31:0] lane_mask = {{16{wstrb_q[3]}}, {16{wstrb_q[1]}}};
    wire [31:0] wbits = wdata_q & lane_mask & `IPG_IMPL_MASK; // see (R6)
    wire hit_cfg = (aw_addr_q == `IPG_OFS_CFG);
    wire hit_set = (aw_addr_q == `IPG_OFS_SET);
    wire hit_clr = (aw_addr_q == `IPG_OFS_CLR);
    wire hit_inv = (aw_addr_q == `IPG_OFS_INV);
    wire w_mapped = hit_cfg | hit_set | hit_clr | hit_inv | (aw_addr_q == `IPG_OFS_STAT);
    wire [31:0] cfg_new = hit_cfg ? ((cfg_q & ~(lane_mask & `IPG_IMPL_MASK)) | wbits) :
                          hit_set ? (cfg_q | wbits) :
                          hit_clr ? (cfg_q & ~wbits) :
                          hit_inv ? (cfg_q ^ wbits) : cfg_q;
    wire cfg_we = w_do & strb_ok; // see (R5)
    wire [31:0] cfg_d = cfg_we ? cfg_new : cfg_q;

    // Read decode; the aliases read back the configuration itself.
    wire r_cfg = (s_axi_araddr == `IPG_OFS_CFG) || (s_axi_araddr == `IPG_OFS_SET) ||
                 (s_axi_araddr == `IPG_OFS_CLR) || (s_axi_araddr == `IPG_OFS_INV);
    wire r_stat = (s_axi_araddr == `IPG_OFS_STAT);
    wire [31:0] stat_word = {8'h00, late_cnt_q, defer_cnt_q, 3'b000, carrier_q,
                             2'b00, state_q};
    wire [31:0] rd_word = r_cfg ? (cfg_q & `IPG_IMPL_MASK) : // see (R6)
                          r_stat ? stat_word : 32'h0000_0000;

    // Write channels: each may arrive first; the response follows both.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_addr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `IPG_RESP_OKAY;
            cfg_q <= `IPG_CFG_RESET;
        end else begin
            s_axi_awready <= ~aw_take & ~aw_hold_q & ~w_do;
            s_axi_wready <= ~w_take & ~w_hold_q & ~w_do;
            if (aw_take) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (w_do) begin
                aw_hold_q <= 1'b0;
            end
            if (w_take) begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (w_do) begin
                w_hold_q <= 1'b0;
            end
            if (w_do) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= w_mapped ? `IPG_RESP_OKAY : `IPG_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            cfg_q <= cfg_d;
        end
    end

    // Read channel: data is captured at the address handshake.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `IPG_RESP_OKAY;
        end else begin
            s_axi_arready <= ~ar_take & ~s_axi_rvalid & ~s_axi_arready;
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= (r_cfg | r_stat) ? `IPG_RESP_OKAY : `IPG_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Gap timing and deference.

    logic [6:0] gap_cnt;
    logic part_one_done;
    logic gap_done;
    logic late_q;

    // A misprogrammed first part above the second simply leaves no room
    // for the second part; software keeps the order.  see (R3)
    ipg_gap_timer u_timer (
        .clk(ref_clk),
        .rst_n(rst_n),
        .restart(state_q == IPG_BUSY), // see (R7)
        .tick(tx_tick),
        .len_one(cfg_q[`IPG_P1_MSB:`IPG_P1_LSB]),
        .len_two(cfg_q[`IPG_P2_MSB:`IPG_P2_LSB]),
        .count(gap_cnt),
        .part_one_done(part_one_done),
        .gap_done(gap_done)
    );

    wire busy_now = carrier_q | tx_active;
    wire grant = (state_q == IPG_READY) & tx_request & ~tx_active & (~carrier_q | late_q);
    wire window_defer = (state_q == IPG_WINDOW) & busy_now; // see (R1)
    wire late_seen = (state_q == IPG_REST) & carrier_q & ~late_q;

    // Phase selection; the carrier window checks carrier before expiry.
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            IPG_BUSY: if (!busy_now) state_d = IPG_WINDOW; // see (R7)
            IPG_WINDOW: begin
                if (busy_now) begin
                    state_d = IPG_BUSY; // see (R1)
                end else if (part_one_done) begin
                    state_d = IPG_REST;
                end
            end
            IPG_REST: begin
                if (tx_active) begin
                    state_d = IPG_BUSY;
                end else if (gap_done) begin
                    state_d = IPG_READY; // see (R2) (R4)
                end
            end
            IPG_READY: begin
                if (grant || tx_active || (carrier_q && !late_q)) begin
                    state_d = IPG_BUSY;
                end
            end
        endcase
    end

    // Phase, grant pulse and deference counters.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= IPG_BUSY;
            late_q <= 1'b0;
            tx_go <= 1'b0;
            deferring <= 1'b1;
            defer_cnt_q <= 8'h00;
            late_cnt_q <= 8'h00;
        end else begin
            state_q <= state_d;
            tx_go <= grant; // see (R2)
            deferring <= (state_d == IPG_BUSY);
            if (state_d == IPG_BUSY) begin
                late_q <= 1'b0;
            end else if (late_seen) begin
                late_q <= 1'b1;
            end
            if (window_defer) begin
                defer_cnt_q <= defer_cnt_q + 8'h01;
            end
            if (late_seen) begin
                late_cnt_q <= late_cnt_q + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    a_window_defers: assert property (@(posedge ref_clk) disable iff (!rst_n) // see (R1)
        (state_q == IPG_WINDOW && carrier_q) |=> (state_q == IPG_BUSY && deferring))
        else $error("carrier in window did not defer");
    a_late_carrier_kept: assert property (@(posedge ref_clk) disable iff (!rst_n) // see (R2)
        (state_q == IPG_REST && carrier_q && !tx_active) |=> (state_q != IPG_BUSY))
        else $error("late carrier aborted the gap");
    a_gap_full_length: assert property (@(posedge ref_clk) disable iff (!rst_n) // see (R4)
        (state_q == IPG_REST && state_d == IPG_READY) |-> (gap_cnt >= cfg_q[6:0]))
        else $error("gap ended before second part length");
    a_byte_write_dropped: assert property (@(posedge ref_clk) disable iff (!rst_n) // see (R5)
        (w_do && !strb_ok) |=> $stable(cfg_q))
        else $error("byte write changed configuration");
    a_unimpl_reads_zero: assert property (@(posedge ref_clk) disable iff (!rst_n) // see (R6)
        $rose(s_axi_rvalid) |-> (s_axi_rdata[7] == 1'b0 || !$past(r_cfg)) &&
        (s_axi_rdata[31:15] == 17'h0_0000 || !$past(r_cfg)))
        else $error("unimplemented bit read as one");
    a_gap_restarts: assert property (@(posedge ref_clk) disable iff (!rst_n) // see (R7)
        (state_q == IPG_BUSY) ##1 (state_q == IPG_WINDOW) |-> (gap_cnt == 7'h00))
        else $error("gap did not restart from zero");
    a_go_needs_ready: assert property (@(posedge ref_clk) disable iff (!rst_n) // see (R2)
        tx_go |-> ($past(state_q) == IPG_READY && $past(tx_request)) ##1 !tx_go)
        else $error("transmit granted outside ready phase");

endmodule : ipg_deference

// >>> verilog/ipg_gap_timer.sv
// Gap timer: counts transmit time units since the medium went quiet.
// Assumes tick is a one-cycle pulse on the same clock, one per time unit.
`timescale 1ns/10ps
`include "ipg_cfg.svh"

module ipg_gap_timer (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Control.
    input wire logic restart,
    input wire logic tick,
    input wire logic [6:0] len_one,
    input wire logic [6:0] len_two,
    // Results.
    output logic [6:0] count,
    output logic part_one_done,
    output logic gap_done
);
    import ipg_pkg::*;

    logic [6:0] cnt_q;
    logic [6:0] cnt_d;

    // The count saturates so that a long quiet spell never wraps back
    // into the carrier window.
    assign cnt_d = restart ? 7'h00 :
                   (tick && cnt_q != `IPG_CNT_MAX) ? cnt_q + 7'h01 : cnt_q;
    assign count = cnt_q;
    assign part_one_done = (cnt_q >= len_one);
    assign gap_done = (cnt_q >= len_two);

    // Counter register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 7'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule : ipg_gap_timer

// >>> verilog/ipg_pkg.sv
// Types shared by the inter-packet gap and deference block.
// Assumes nothing of its surroundings.
package ipg_pkg;

    // Gap phases, Gray coded along busy, window, remainder, ready.
    typedef enum logic [1:0] {
        IPG_BUSY = 2'b00,
        IPG_WINDOW = 2'b01,
        IPG_REST = 2'b11,
        IPG_READY = 2'b10
    } ipg_phase_type;

endpackage : ipg_pkg
